// ---- hdl/cpr_map.vh ----
// Constants for the configuration memory readout block
`ifndef CPR_MAP_VH
`define CPR_MAP_VH

`define CPR_CLOCK_MHZ 25
`define CPR_ADDR_W 19
`define CPR_WORDS 524288
`define CPR_LAST_BYTE 19'h7FFFF
`define CPR_BIT_IDX_W 3
`define CPR_LAST_BIT 3'h7
`define CPR_RESTART_NS 400
`define CPR_RESTART_CYCLES ((`CPR_RESTART_NS * `CPR_CLOCK_MHZ) / 1000)
`define CPR_CNT_W 16
`define CPR_POWERUP_US 1000
`define CPR_POWERUP_CYCLES (`CPR_POWERUP_US * `CPR_CLOCK_MHZ)
`define CPR_OPC_W 8
`define CPR_OPC_LAUNCH 8'hEE
`define CPR_MODE_SERIAL 1'b0
`define CPR_MODE_PARALLEL 1'b1

`endif

// ---- hdl/cpr_pulse.v ----
// Fixed-length active-low pulse generator
`timescale 1ns/1ps
module cpr_pulse #(
    parameter [15:0] LENGTH = 16'h000A
) (
    input wire clk,
    input wire nrst,
    input wire start,
    output reg pulse_n,
    output wire busy
);
    reg [15:0] count;

    assign busy = (count != 16'h0000);

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count <= 16'h0000;
            pulse_n <= 1'b1;
        end else if (start && !busy) begin
            count <= LENGTH;
            pulse_n <= 1'b0;
        end else if (busy) begin
            count <= count - 16'h0001;
            pulse_n <= (count == 16'h0001);
        end else begin
            pulse_n <= 1'b1;
        end
    end
endmodule

// ---- hdl/cpr_array.v ----
// Stored bitstream array, one byte per address, synchronous read
`timescale 1ns/1ps
`include "cpr_map.vh"
module cpr_array (
    input wire clk,
    input wire [`CPR_ADDR_W-1:0] rd_addr,
    output reg [7:0] rd_data,
    input wire wr_en,
    input wire [`CPR_ADDR_W-1:0] wr_addr,
    input wire [7:0] wr_data
);
    reg [7:0] mem [0:`CPR_WORDS-1];

    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// ---- hdl/cpr_readout.v ----
// Configuration memory readout: serial/parallel stream, cascade, restart pulse
// The memory array has a one-cycle read latency. The next byte is fetched
// a cycle ahead so that each clock edge can present fresh data.
`timescale 1ns/1ps
`include "cpr_map.vh"
module cpr_readout #(
    parameter [15:0] POWERUP_CYCLES = `CPR_POWERUP_CYCLES
) (
    input wire CLOCK,
    input wire NRST,
    input wire OE_RESET_IN,
    output reg OE_RESET_OUT,
    output reg OE_RESET_OE,
    input wire CHIP_ENABLE_N,
    input wire BROWNOUT,
    input wire MODE_WRITE,
    input wire MODE_PARALLEL,
    output reg MODE_STATUS,
    input wire OPCODE_VALID,
    input wire [7:0] OPCODE,
    input wire LOAD_EN,
    input wire [`CPR_ADDR_W-1:0] LOAD_ADDR,
    input wire [7:0] LOAD_DATA,
    output reg [7:0] BYTE_OUT_LINES,
    output reg [7:0] BYTE_OUT_OE,
    output reg CASCADE_ENABLE_OUT_N,
    output reg TARGET_RESTART_OUT,
    output reg LAST_ADDRESS
);
    localparam ST_IDLE = 2'b00;
    localparam ST_PRIME = 2'b01;
    localparam ST_STREAM = 2'b10;
    localparam ST_DONE = 2'b11;

    localparam [15:0] RESTART_LEN = `CPR_RESTART_CYCLES;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [`CPR_ADDR_W-1:0] fetch_addr;
    reg [`CPR_ADDR_W-1:0] cur_addr;
    reg [`CPR_BIT_IDX_W-1:0] bit_idx;
    reg [7:0] shift_byte;
    reg parallel_mode;
    reg [15:0] powerup_count;
    reg powerup_done;
    wire [7:0] array_data;
    wire restart_n;
    wire restart_busy;
    wire hold_reset;
    wire at_last_byte;
    wire byte_done;

    // Reset input low, chip enable high, or brownout all clear the address
    assign hold_reset = !OE_RESET_IN || CHIP_ENABLE_N || BROWNOUT || !powerup_done;
    assign at_last_byte = (cur_addr == `CPR_LAST_BYTE);
    assign byte_done = parallel_mode || (bit_idx == `CPR_LAST_BIT);

    cpr_array u_array (
        .clk(CLOCK),
        .rd_addr(fetch_addr),
        .rd_data(array_data),
        .wr_en(LOAD_EN),
        .wr_addr(LOAD_ADDR),
        .wr_data(LOAD_DATA)
    );

    cpr_pulse #(
        .LENGTH(RESTART_LEN)
    ) u_restart (
        .clk(CLOCK),
        .nrst(NRST),
        .start(OPCODE_VALID && (OPCODE == `CPR_OPC_LAUNCH)),
        .pulse_n(restart_n),
        .busy(restart_busy)
    );

    // Power-up hold of the shared reset line
    always @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            powerup_count <= 16'h0000;
            powerup_done <= 1'b0;
        end else if (BROWNOUT) begin
            powerup_count <= 16'h0000;
            powerup_done <= 1'b0;
        end else if (!powerup_done) begin
            powerup_count <= powerup_count + 16'h0001;
            powerup_done <= (powerup_count >= POWERUP_CYCLES - 16'h0001);
        end
    end

    always @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            OE_RESET_OUT <= 1'b0;
            OE_RESET_OE <= 1'b1;
            TARGET_RESTART_OUT <= 1'b1;
            parallel_mode <= `CPR_MODE_SERIAL;
            MODE_STATUS <= `CPR_MODE_SERIAL;
        end else begin
            OE_RESET_OUT <= 1'b0;
            OE_RESET_OE <= !powerup_done || BROWNOUT;
            TARGET_RESTART_OUT <= restart_n;
            if (MODE_WRITE) begin
                parallel_mode <= MODE_PARALLEL;
                MODE_STATUS <= MODE_PARALLEL;
            end
        end
    end

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                next_state = ST_PRIME;
            end
            ST_PRIME: begin
                next_state = ST_STREAM;
            end
            ST_STREAM: begin
                if (byte_done && at_last_byte) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                next_state = ST_DONE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            state <= ST_IDLE;
            fetch_addr <= {`CPR_ADDR_W{1'b0}};
            cur_addr <= {`CPR_ADDR_W{1'b0}};
            bit_idx <= {`CPR_BIT_IDX_W{1'b0}};
            shift_byte <= 8'h00;
            BYTE_OUT_LINES <= 8'h00;
            BYTE_OUT_OE <= 8'h00;
            CASCADE_ENABLE_OUT_N <= 1'b1;
            LAST_ADDRESS <= 1'b0;
        end else if (hold_reset) begin
            state <= ST_IDLE;
            fetch_addr <= {`CPR_ADDR_W{1'b0}};
            cur_addr <= {`CPR_ADDR_W{1'b0}};
            bit_idx <= {`CPR_BIT_IDX_W{1'b0}};
            BYTE_OUT_OE <= 8'h00;
            CASCADE_ENABLE_OUT_N <= 1'b1;
            LAST_ADDRESS <= 1'b0;
        end else begin
            state <= next_state;
            case (state)
                ST_IDLE: begin
                    // Address 0 is on the array input; step the prefetch
                    fetch_addr <= fetch_addr + 1'b1;
                end
                ST_PRIME: begin
                    shift_byte <= array_data;
                    // Serial mode holds the prefetch for 8 clocks, so it stays one byte ahead;
                    // parallel mode reads every clock and so runs two ahead
                    fetch_addr <= fetch_addr + {{(`CPR_ADDR_W-1){1'b0}}, parallel_mode};
                    cur_addr <= {`CPR_ADDR_W{1'b0}};
                    bit_idx <= {`CPR_BIT_IDX_W{1'b0}};
                end
                ST_STREAM: begin
                    // Enable when chip enable seen low, present first data
                    if (parallel_mode) begin
                        BYTE_OUT_LINES <= shift_byte;
                        BYTE_OUT_OE <= 8'hFF;
                    end else begin
                        BYTE_OUT_LINES <= {7'h00, shift_byte[7 - bit_idx]};
                        BYTE_OUT_OE <= 8'h01;
                    end
                    LAST_ADDRESS <= at_last_byte;
                    if (byte_done) begin
                        shift_byte <= array_data;
                        fetch_addr <= fetch_addr + 1'b1;
                        cur_addr <= cur_addr + 1'b1;
                        bit_idx <= {`CPR_BIT_IDX_W{1'b0}};
                    end else begin
                        bit_idx <= bit_idx + 1'b1;
                    end
                end
                ST_DONE: begin
                    // Past the last address: hold, float, hand over
                    BYTE_OUT_OE <= 8'h00;
                    CASCADE_ENABLE_OUT_N <= 1'b0;
                    LAST_ADDRESS <= 1'b1;
                end
                default: begin
                    BYTE_OUT_OE <= 8'h00;
                end
            endcase
        end
    end
endmodule

// ---- sim/cpr_readout_properties.sv ----
// Assertion checker bound to the readout block
`timescale 1ns/1ps
module cpr_readout_properties #(
    parameter [15:0] POWERUP_CYCLES = 16'd20
) (
    input wire CLOCK,
    input wire NRST,
    input wire OE_RESET_IN,
    input wire OE_RESET_OE,
    input wire CHIP_ENABLE_N,
    input wire BROWNOUT,
    input wire MODE_WRITE,
    input wire MODE_PARALLEL,
    input wire MODE_STATUS,
    input wire OPCODE_VALID,
    input wire [7:0] OPCODE,
    input wire [7:0] BYTE_OUT_OE,
    input wire CASCADE_ENABLE_OUT_N,
    input wire TARGET_RESTART_OUT
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    reg [15:0] cnt;
    wire go = OPCODE_VALID && OPCODE == 8'hEE;
    always @(posedge CLOCK or negedge NRST) begin
        if (!NRST) cnt <= 16'h0000;
        else if (cnt < POWERUP_CYCLES) cnt <= cnt + 16'h0001;
    end
    a_powerup_hold: assert property (cnt + 16'h0002 < POWERUP_CYCLES |-> OE_RESET_OE)
        else $error("reset pin released early");
    a_serial_lines: assert property (!MODE_STATUS && !$past(MODE_STATUS) && BYTE_OUT_OE != 8'h00 |-> BYTE_OUT_OE == 8'h01)
        else $error("serial enables wrong");
    a_parallel_lines: assert property (MODE_STATUS && $past(MODE_STATUS) && BYTE_OUT_OE != 8'h00 |-> BYTE_OUT_OE == 8'hFF)
        else $error("parallel enables wrong");
    a_standby_float: assert property (CHIP_ENABLE_N |=> BYTE_OUT_OE == 8'h00 && CASCADE_ENABLE_OUT_N)
        else $error("standby outputs active");
    a_reset_float: assert property (!OE_RESET_IN |=> BYTE_OUT_OE == 8'h00 && CASCADE_ENABLE_OUT_N)
        else $error("reset outputs active");
    a_brownout_hold: assert property (BROWNOUT |=> OE_RESET_OE && BYTE_OUT_OE == 8'h00)
        else $error("brownout not held");
    a_cascade_float: assert property (!CASCADE_ENABLE_OUT_N |-> BYTE_OUT_OE == 8'h00)
        else $error("cascade low with data on");
    a_mode_load: assert property (MODE_WRITE |=> MODE_STATUS == $past(MODE_PARALLEL))
        else $error("mode not loaded");
    a_restart_start: assert property (go && TARGET_RESTART_OUT && !$past(go) && !$past(go, 2) |-> ##2 !TARGET_RESTART_OUT)
        else $error("restart not started");
    a_restart_len: assert property ($fell(TARGET_RESTART_OUT) |-> !TARGET_RESTART_OUT [*8] ##1 !TARGET_RESTART_OUT ##1 !TARGET_RESTART_OUT ##1 TARGET_RESTART_OUT)
        else $error("restart length wrong");
    c_parallel: cover property (BYTE_OUT_OE == 8'hFF);
    c_serial: cover property (BYTE_OUT_OE == 8'h01);
    c_restart: cover property ($fell(TARGET_RESTART_OUT));
endmodule
bind cpr_readout cpr_readout_properties #(.POWERUP_CYCLES(POWERUP_CYCLES)) i_cpr_props (
    .CLOCK(CLOCK), .NRST(NRST), .OE_RESET_IN(OE_RESET_IN), .OE_RESET_OE(OE_RESET_OE),
    .CHIP_ENABLE_N(CHIP_ENABLE_N), .BROWNOUT(BROWNOUT), .MODE_WRITE(MODE_WRITE),
    .MODE_PARALLEL(MODE_PARALLEL), .MODE_STATUS(MODE_STATUS), .OPCODE_VALID(OPCODE_VALID),
    .OPCODE(OPCODE), .BYTE_OUT_OE(BYTE_OUT_OE), .CASCADE_ENABLE_OUT_N(CASCADE_ENABLE_OUT_N),
    .TARGET_RESTART_OUT(TARGET_RESTART_OUT));

// ---- sim/cpr_target.sv ----
// Target-side model: reset pin resolution and data capture
`timescale 1ns/1ps
module cpr_target (
    input wire clock,
    input wire init_n,
    input wire reset_pin_oe,
    input wire [7:0] lines,
    input wire [7:0] lines_oe,
    output wire reset_pin,
    output reg [7:0] captured,
    output reg got
);
    // Pin pulled high unless the memory or the target holds it low
    assign reset_pin = reset_pin_oe ? 1'b0 : init_n;
    // Floated lines read back as the inverse of the last value
    always @(posedge clock) begin
        captured <= (lines & lines_oe) | (~captured & ~lines_oe);
        got <= |lines_oe;
    end
endmodule

// ---- sim/test_config_prom_readout.sv ----
// Self-checking bench for the readout block
`timescale 1ns/1ps
module test_config_prom_readout;
    reg CLOCK = 1'b0;
    reg NRST = 1'b0;
    reg init_n = 1'b0;
    reg ce_n = 1'b1;
    reg brown = 1'b0;
    reg mwr = 1'b0;
    reg mpar = 1'b0;
    reg opv = 1'b0;
    reg [7:0] opc = 8'h00;
    reg ld = 1'b0;
    reg [18:0] la = 19'h00000;
    reg [7:0] ldat = 8'h00;
    reg [7:0] mem [0:3];
    wire rst_pin, rst_out, rst_oe, mst, ceo_n, cf_n, last, got;
    wire [7:0] lines, loe, cap;
    integer n_mismatch = 0;
    integer samples_checked = 0;
    integer i;
    cpr_readout #(.POWERUP_CYCLES(16'd20)) i_cpr_readout (
        .CLOCK(CLOCK), .NRST(NRST), .OE_RESET_IN(rst_pin), .OE_RESET_OUT(rst_out),
        .OE_RESET_OE(rst_oe), .CHIP_ENABLE_N(ce_n), .BROWNOUT(brown), .MODE_WRITE(mwr),
        .MODE_PARALLEL(mpar), .MODE_STATUS(mst), .OPCODE_VALID(opv), .OPCODE(opc),
        .LOAD_EN(ld), .LOAD_ADDR(la), .LOAD_DATA(ldat), .BYTE_OUT_LINES(lines),
        .BYTE_OUT_OE(loe), .CASCADE_ENABLE_OUT_N(ceo_n), .TARGET_RESTART_OUT(cf_n),
        .LAST_ADDRESS(last));
    cpr_target i_cpr_target (.clock(CLOCK), .init_n(init_n), .reset_pin_oe(rst_oe),
        .lines(lines), .lines_oe(loe), .reset_pin(rst_pin), .captured(cap), .got(got));
    always #20 CLOCK = ~CLOCK;
    function [7:0] exp_item(input par, input integer k);
        exp_item = par ? mem[k] : {7'h00, mem[k / 8][7 - k % 8]};
    endfunction
    task check(input [7:0] v, input [7:0] e);
        begin
            samples_checked = samples_checked + 1;
            if (v !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("unexpected at %0t: got %h expected %h", $time, v, e);
            end
        end
    endtask
    task test_done;
        begin
            if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
            else $display("bench failed");
            $finish;
        end
    endtask
    task tick(input integer n);
        begin
            repeat (n) @(posedge CLOCK);
            #1;
        end
    endtask
    task stream(input par, input integer n);
        integer k;
        begin
            mwr = 1'b1;
            mpar = par;
            tick(1);
            mwr = 1'b0;
            tick(1);
            check({7'h00, mst}, {7'h00, par});
            ce_n = 1'b0;
            for (k = 0; !got && k < 8; k = k + 1) tick(1);
            check({7'h00, got}, 8'h01);
            for (k = 0; k < n; k = k + 1) begin
                check(par ? cap : {7'h00, cap[0]}, exp_item(par, k));
                check(loe, par ? 8'hFF : 8'h01);
                check({6'h00, last, ceo_n}, 8'h01);
                tick(1);
            end
            ce_n = 1'b1;
            tick(2);
            check(loe, 8'h00);
        end
    endtask
    task launch(input [7:0] op, input low);
        begin
            opv = 1'b1;
            opc = op;
            tick(1);
            opv = 1'b0;
            tick(2);
            check({7'h00, cf_n}, {7'h00, !low});
            tick(8);
            check({7'h00, cf_n}, {7'h00, !low});
            tick(1);
            check({7'h00, cf_n}, 8'h01);
        end
    endtask
    initial begin
        #200000;
        n_mismatch = n_mismatch + 1;
        test_done;
    end
    initial begin
        i = $urandom(16522);
        tick(4);
        NRST = 1'b1;
        for (i = 0; i < 4; i = i + 1) begin
            mem[i] = (i == 0) ? 8'h01 : $urandom;
            ld = 1'b1;
            la = i;
            ldat = mem[i];
            tick(1);
        end
        ld = 1'b0;
        check({7'h00, rst_oe}, 8'h01);
        check({7'h00, rst_out}, 8'h00);
        tick(30);
        init_n = 1'b1;
        check({7'h00, rst_oe}, 8'h00);
        stream(1'b1, 4);
        stream(1'b0, 32);
        launch(8'hFF, 1'b0);
        launch(8'hEE, 1'b1);
        brown = 1'b1;
        tick(1);
        brown = 1'b0;
        check({7'h00, rst_oe}, 8'h01);
        tick(30);
        stream(1'b1, 4);
        test_done;
    end
endmodule
